// ==== mmac_pkg.sv ====
// Shared constants and types for the address translation and mode control block
package mmac_pkg;

	// CPU modes; reset value is boot
	typedef enum logic [2:0]
	{
		MODE_BOOT = 3'h0,
		MODE_TEST = 3'h1,
		MODE_FW   = 3'h2,
		MODE_SYS  = 3'h3,
		MODE_USER = 3'h4
	} mmac_mode_e;

	// Segment table fetch sequencer
	typedef enum logic [0:0]
	{
		FETCH_IDLE = 1'h0,
		FETCH_WAIT = 1'h1
	} mmac_fetch_e;

	// CPU access kinds
	localparam logic [1:0] OP_READ  = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_FETCH = 2'h2;

	// Segment rights codes, low three bits of the first entry word
	localparam logic [2:0] RT_DENY = 3'h0;
	localparam logic [2:0] RT_EXEC = 3'h1;
	localparam logic [2:0] RT_RW   = 3'h2;
	localparam logic [2:0] RT_RWX  = 3'h3;
	localparam logic [2:0] RT_LINK = 3'h6;
	localparam logic [2:0] RT_END  = 3'h7;
	localparam int         LINK_LSB = 8;

	// Entry word order in memory
	localparam logic [2:0] FLD_RIGHTS = 3'h0;
	localparam logic [2:0] FLD_START  = 3'h1;
	localparam logic [2:0] FLD_END    = 3'h2;
	localparam logic [2:0] FLD_OFF    = 3'h3;
	localparam logic [2:0] FLD_SFR    = 3'h4;

	localparam int          SEG_NUM  = 64;
	localparam logic [5:0]  SEG_LAST = 6'h3F;
	localparam logic [23:0] TBL_STEP = 24'h000004;

	// Register port offsets
	localparam logic [7:0] REG_MODE      = 8'h00;
	localparam logic [7:0] REG_BOOT_EXIT = 8'h04;
	localparam logic [7:0] REG_IRQ_MODE  = 8'h08;
	localparam logic [7:0] REG_TBL_BASE  = 8'h0C;
	localparam logic [7:0] REG_TBL_LOAD  = 8'h10;
	localparam logic [7:0] REG_USER_GRP  = 8'h14;
	localparam logic [7:0] REG_FW_GRP    = 8'h18;
	localparam logic [7:0] REG_SEG_CNT   = 8'h1C;
	localparam logic [7:0] REG_BANKED    = 8'h20;
	localparam int         MC_PRIV_BIT   = 0;
	localparam int         MC_EXC_BIT    = 3;
	localparam int         MC_IRQ_BIT    = 4;
	localparam int         MC_BUSY_BIT   = 5;
	localparam int         BX_TEST_BIT   = 0;

	// Banked copy selection
	localparam logic [1:0] BANK_USER  = 2'h0;
	localparam logic [1:0] BANK_SYS   = 2'h1;
	localparam logic [1:0] BANK_SUPER = 2'h2;

	// Physical regions: 0 app ROM, 1 app NV, 2 app RAM, 3 test ROM, 4 fw NV, 5 fw RAM
	localparam int RGN_NUM = 6;
	localparam logic [5:0][23:0] RGN_LO = {24'h302000, 24'h240000, 24'h000000,
		24'h300000, 24'h200000, 24'h100000};
	localparam logic [5:0][23:0] RGN_HI = {24'h302FFF, 24'h24FFFF, 24'h00FFFF,
		24'h301FFF, 24'h23FFFF, 24'h17FFFF};
	localparam logic [5:0] RGN_FW = 6'h38;

	// Vector pages and user entry point
	localparam int          VEC_LSB    = 16;
	localparam logic [7:0]  SYSTEM_CALL_VECTOR_PAGE  = 8'hFF;
	localparam logic [7:0]  FIRMWARE_CALL_VECTOR_PAGE  = 8'hFE;
	localparam logic [23:0] USER_ENTRY = 24'h800000;

	// Special function register map
	localparam logic [7:0] SFR_CORE_END    = 8'h40;
	localparam logic [7:0] SFR_PERIPH_BASE = 8'hC0;
	localparam int         SFR_GRP_LSB     = 2;
	localparam logic [3:0] SFR_RNG_GRP     = 4'h1;
	localparam logic [3:0] SFR_KEY_GRP     = 4'h2;
	localparam logic [1:0] SFR_RNG_OUT     = 2'h0;

endpackage

// ==== mmac_seg_table.sv ====
// Segment table storage and virtual address lookup
`timescale 1ns/100ps
module mmac_seg_table
(
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire logic        wr_i,
	input  wire logic [5:0]  idx_i,
	input  wire logic [2:0]  fld_i,
	input  wire logic [31:0] data_i,
	input  wire logic [6:0]  cnt_i,
	input  wire logic [23:0] vaddr_i,
	output logic             hit_o,
	output logic [2:0]       rights_o,
	output logic [23:0]      off_o,
	output logic [15:0]      sfr_o
);
	typedef struct packed
	{
		logic [63:0][2:0]  rights;
		logic [63:0][23:0] lo;
		logic [63:0][23:0] hi;
		logic [63:0][23:0] off;
		logic [63:0][15:0] sfr;
	} mmac_seg_s;

	mmac_seg_s        s_r;
	mmac_seg_s        s_nxt;
	logic [63:0]      hit_vec;

	// Entry words land one field at a time
	always_comb
	begin
		s_nxt = s_r;
		if (wr_i)
		begin
			case (fld_i)
				mmac_pkg::FLD_RIGHTS: s_nxt.rights[idx_i] = data_i[2:0];
				mmac_pkg::FLD_START:  s_nxt.lo[idx_i] = data_i[23:0];
				mmac_pkg::FLD_END:    s_nxt.hi[idx_i] = data_i[23:0];
				mmac_pkg::FLD_OFF:    s_nxt.off[idx_i] = data_i[23:0];
				mmac_pkg::FLD_SFR:    s_nxt.sfr[idx_i] = data_i[15:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	// Only fully loaded entries take part; bounds are inclusive
	genvar i;
	generate
		for (i = 0; i < mmac_pkg::SEG_NUM; i++)
		begin : g_hit
			assign hit_vec[i] = (7'(i) < cnt_i) && (vaddr_i >= s_r.lo[i]) // [R08]
				&& (vaddr_i <= s_r.hi[i]); // [R24]
		end
	endgenerate

	// Lowest matching index wins where segments overlap
	always_comb
	begin
		hit_o    = 1'b0;
		rights_o = mmac_pkg::RT_DENY;
		off_o    = '0;
		sfr_o    = '0;
		for (int k = mmac_pkg::SEG_NUM - 1; k >= 0; k--)
		begin
			if (hit_vec[k])
			begin
				hit_o    = 1'b1;
				rights_o = s_r.rights[k];
				off_o    = s_r.off[k];
				sfr_o    = s_r.sfr[k];
			end
		end
	end
endmodule

// ==== mmac_sfr_check.sv ====
// Special function register access decision, purely combinational
`timescale 1ns/100ps
module mmac_sfr_check
(
	input  wire logic [2:0]  mode_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic        wr_i,
	input  wire logic [15:0] user_grp_i,
	input  wire logic [15:0] fw_grp_i,
	input  wire logic [15:0] seg_sfr_i,
	output logic             ok_o
);
	logic       is_core;
	logic       is_periph;
	logic [3:0] grp;
	logic [1:0] sub;
	logic       grant;

	assign is_core   = addr_i < mmac_pkg::SFR_CORE_END;
	assign is_periph = addr_i >= mmac_pkg::SFR_PERIPH_BASE;
	assign grp       = addr_i[mmac_pkg::SFR_GRP_LSB +: 4];
	assign sub       = addr_i[1:0];

	// Group grants per mode; other modes see every group
	always_comb
	begin
		case (mode_i)
			mmac_pkg::MODE_USER: grant = user_grp_i[grp] & seg_sfr_i[grp]; // [R11] [R16]
			mmac_pkg::MODE_FW:   grant = fw_grp_i[grp]; // [R11] [R16]
			default:             grant = 1'b1;
		endcase
	end

	// Core registers have fixed rights that no code can alter
	always_comb
	begin
		ok_o = 1'b0;
		if (is_core)
			ok_o = !wr_i || (mode_i != mmac_pkg::MODE_USER); // [R15]
		else if (is_periph)
		begin
			ok_o = grant;
			if (grp == mmac_pkg::SFR_KEY_GRP && !wr_i)
				ok_o = 1'b0; // [R12]
			if (grp == mmac_pkg::SFR_RNG_GRP && sub == mmac_pkg::SFR_RNG_OUT && wr_i)
				ok_o = 1'b0; // [R12]
		end
	end
endmodule

// ==== mmac_core.sv ====
// Address translation, partition and segment checks, register access and CPU mode control
//
// Overview of operation
// R01: Translate every virtual address before memory access
// R02: Boot and firmware see firmware parts; others application
// R03: Test mode may reach both partitions
// R04: Read and write share one right; exec-only, deny
// R05: Segments set in system mode, checked in user
// R06: Entry holds rights, start, end, offset, group rights
// R07: Relocated address still bound by mode partition
// R08: At most 64 segments, fewer allowed
// R09: Table fetched from memory; end and link codes
// R10: Exception for unimplemented memory, forbidden user access; test mode raises none for unimplemented memory
// R11: Per-group rights for user and firmware, 16 groups
// R12: Key registers unreadable; generator output read-only
// R13: Forbidden or unimplemented register access raises exception
// R14: Banked register copies selected by current mode
// R15: Non-peripheral register rights fixed in hardware
// R16: Peripheral groups blocked until system code grants them
// R17: Vector calls enter system or firmware; misuse traps
// R18: Exception sets status; second exception forces reset
// R19: System code selects the interrupt handler mode
// R20: Return restores mode; user return needs interrupt
// R21: Call to user entry from system enters user
// R22: Mode bit writes only clear, never set
// R23: Boot may be left but never re-entered
// R24: Segment bounds inclusive at both ends
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module mmac_core
(
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic [31:0]      reg_rdata_o,
	input  wire logic        test_allow_i,
	input  wire logic        cpu_req_i,
	input  wire logic [23:0] cpu_vaddr_i,
	input  wire logic [1:0]  cpu_op_i,
	input  wire logic        cpu_sfr_req_i,
	input  wire logic [7:0]  cpu_sfr_addr_i,
	input  wire logic        cpu_sfr_wr_i,
	input  wire logic        cpu_call_i,
	input  wire logic        cpu_return_from_interrupt_i,
	input  wire logic        cpu_irq_i,
	output logic             mem_req_o,
	output logic [23:0]      mem_paddr_o,
	output logic [1:0]       mem_op_o,
	output logic             sfr_grant_o,
	output logic             exc_o,
	output logic             dev_reset_o,
	output logic [2:0]       mode_o,
	output logic             no_push_o,
	output logic             tbl_req_o,
	output logic [23:0]      tbl_addr_o,
	input  wire logic [31:0] tbl_data_i,
	input  wire logic        tbl_valid_i
);
	typedef struct packed
	{
		mmac_pkg::mmac_mode_e  mode;
		mmac_pkg::mmac_mode_e  prev;
		mmac_pkg::mmac_mode_e  irq_mode;
		logic                  exc_status;
		logic                  irq_active;
		logic [1:0]            tsync;
		logic [15:0]           user_grp;
		logic [15:0]           fw_grp;
		logic [15:0]           seg_sfr;
		logic [2:0][15:0]      bank;
		logic [23:0]           tbl_base;
		logic [23:0]           tbl_ptr;
		mmac_pkg::mmac_fetch_e fst;
		logic [2:0]            fword;
		logic [5:0]            fidx;
		logic [6:0]            seg_cnt;
		logic                  mem_req;
		logic [23:0]           mem_paddr;
		logic [1:0]            mem_op;
		logic                  sfr_grant;
		logic                  exc;
		logic                  dev_reset;
		logic                  no_push;
		logic                  tbl_req;
		logic [31:0]           rdata;
	} mmac_state_s;

	mmac_state_s s_r;
	mmac_state_s s_nxt;
	logic        seg_hit;
	logic [2:0]  seg_rights;
	logic [23:0] seg_off;
	logic [15:0] seg_sfr;
	logic        seg_we;
	logic [2:0]  seg_fld;
	logic        sfr_ok;
	logic [23:0] acc_paddr;
	logic [5:0]  in_rgn;
	logic        acc_impl;
	logic        part_ok;
	logic        right_ok;
	logic        acc_bad;
	logic        exc_ev;
	logic        is_user;
	logic        is_system_call_vector;
	logic        is_firmware_call_vector;
	logic [1:0]  bank_sel;

	assign is_user = s_r.mode == mmac_pkg::MODE_USER;
	assign is_system_call_vector = cpu_vaddr_i[mmac_pkg::VEC_LSB +: 8] == mmac_pkg::SYSTEM_CALL_VECTOR_PAGE;
	assign is_firmware_call_vector = cpu_vaddr_i[mmac_pkg::VEC_LSB +: 8] == mmac_pkg::FIRMWARE_CALL_VECTOR_PAGE;

	mmac_seg_table u_seg
	(
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.wr_i       (seg_we),
		.idx_i      (s_r.fidx),
		.fld_i      (seg_fld),
		.data_i     (tbl_data_i),
		.cnt_i      (s_r.seg_cnt),
		.vaddr_i    (cpu_vaddr_i),
		.hit_o      (seg_hit),
		.rights_o   (seg_rights),
		.off_o      (seg_off),
		.sfr_o      (seg_sfr)
	);

	mmac_sfr_check u_sfr
	(
		.mode_i     (s_r.mode),
		.addr_i     (cpu_sfr_addr_i),
		.wr_i       (cpu_sfr_wr_i),
		.user_grp_i (s_r.user_grp),
		.fw_grp_i   (s_r.fw_grp),
		.seg_sfr_i  (s_r.seg_sfr),
		.ok_o       (sfr_ok)
	);

	// Relocation applies to user code only; other modes map one to one
	assign acc_paddr = is_user ? cpu_vaddr_i + seg_off : cpu_vaddr_i; // [R01] [R07]

	// Which physical region the translated address falls into
	genvar r;
	generate
		for (r = 0; r < mmac_pkg::RGN_NUM; r++)
		begin : g_rgn
			assign in_rgn[r] = (acc_paddr >= mmac_pkg::RGN_LO[r])
				&& (acc_paddr <= mmac_pkg::RGN_HI[r]);
		end
	endgenerate
	assign acc_impl = |in_rgn;

	// Fixed partition per mode, decided after relocation
	always_comb
	begin
		case (s_r.mode)
			mmac_pkg::MODE_TEST: part_ok = 1'b1; // [R03]
			mmac_pkg::MODE_BOOT,
			mmac_pkg::MODE_FW:   part_ok = |(in_rgn & mmac_pkg::RGN_FW); // [R02]
			default:             part_ok = |(in_rgn & ~mmac_pkg::RGN_FW); // [R02] [R07]
		endcase
	end

	// Read and write share one right; fetch needs execute
	always_comb
	begin
		if (cpu_op_i == mmac_pkg::OP_FETCH)
			right_ok = seg_rights == mmac_pkg::RT_EXEC || seg_rights == mmac_pkg::RT_RWX;
		else
			right_ok = seg_rights == mmac_pkg::RT_RW || seg_rights == mmac_pkg::RT_RWX; // [R04]
	end

	// Segments only bite in user mode; test mode may probe holes
	always_comb
	begin
		acc_bad = 1'b0;
		if (is_user && !(seg_hit && right_ok))
			acc_bad = 1'b1; // [R05] [R10]
		if (!acc_impl && s_r.mode != mmac_pkg::MODE_TEST)
			acc_bad = 1'b1; // [R10]
		if (acc_impl && !part_ok)
			acc_bad = 1'b1; // [R02] [R07]
	end

	// Banked copy index follows the mode
	always_comb
	begin
		case (s_r.mode)
			mmac_pkg::MODE_USER: bank_sel = mmac_pkg::BANK_USER;
			mmac_pkg::MODE_SYS:  bank_sel = mmac_pkg::BANK_SYS;
			default:             bank_sel = mmac_pkg::BANK_SUPER;
		endcase
	end

	// Next-state logic: accesses, mode changes, register port, table fetch
	always_comb
	begin
		s_nxt           = s_r;
		s_nxt.tsync     = {s_r.tsync[0], test_allow_i};
		s_nxt.mem_req   = 1'b0;
		s_nxt.sfr_grant = 1'b0;
		s_nxt.exc       = 1'b0;
		s_nxt.dev_reset = 1'b0;
		s_nxt.no_push   = 1'b0;
		s_nxt.tbl_req   = 1'b0;
		s_nxt.rdata     = '0;
		seg_we          = 1'b0;
		seg_fld         = s_r.fword;
		exc_ev          = 1'b0;
		// Memory access
		if (cpu_req_i)
		begin
			s_nxt.mem_req   = !acc_bad; // [R01]
			s_nxt.mem_paddr = acc_paddr;
			s_nxt.mem_op    = cpu_op_i;
			exc_ev          = acc_bad; // [R10]
			if (is_user && seg_hit && cpu_op_i == mmac_pkg::OP_FETCH)
				s_nxt.seg_sfr = seg_sfr; // [R06]
		end
		// Special function register access
		if (cpu_sfr_req_i)
		begin
			s_nxt.sfr_grant = sfr_ok;
			if (!sfr_ok)
				exc_ev = 1'b1; // [R13]
		end
		// Calls: vectors and the user entry point
		if (cpu_call_i)
		begin
			if (is_system_call_vector)
			begin
				if (is_user)
				begin
					s_nxt.prev = s_r.mode;
					s_nxt.mode = mmac_pkg::MODE_SYS; // [R17]
				end
				else
					exc_ev = 1'b1; // [R17]
			end
			else if (is_firmware_call_vector)
			begin
				s_nxt.prev = s_r.mode;
				s_nxt.mode = mmac_pkg::MODE_FW; // [R17]
			end
			else if (cpu_vaddr_i == mmac_pkg::USER_ENTRY && s_r.mode == mmac_pkg::MODE_SYS)
			begin
				s_nxt.mode    = mmac_pkg::MODE_USER; // [R21]
				s_nxt.no_push = 1'b1; // [R21]
			end
		end
		// Interrupt entry into the configured handler mode
		if (cpu_irq_i)
		begin
			s_nxt.prev       = s_r.mode;
			s_nxt.irq_active = 1'b1;
			// Unconfigured handler mode falls back to system, never to boot
			s_nxt.mode       = (s_r.irq_mode == mmac_pkg::MODE_BOOT)
				? mmac_pkg::MODE_SYS : s_r.irq_mode; // [R19] [R23]
		end
		// Return: user mode needs user interrupts and one active
		if (cpu_return_from_interrupt_i)
		begin
			if (is_user && !(s_r.irq_mode == mmac_pkg::MODE_USER && s_r.irq_active))
				exc_ev = 1'b1; // [R20]
			else
			begin
				// A save taken in boot returns to firmware; boot is left for good
				s_nxt.mode       = (s_r.prev == mmac_pkg::MODE_BOOT)
					? mmac_pkg::MODE_FW : s_r.prev; // [R20] [R23]
				s_nxt.irq_active = 1'b0;
				s_nxt.exc_status = 1'b0;
			end
		end
		// A second exception while the status stands resets the device
		if (exc_ev)
		begin
			s_nxt.exc        = 1'b1;
			s_nxt.exc_status = 1'b1; // [R18]
			if (s_r.exc_status)
				s_nxt.dev_reset = 1'b1; // [R18]
		end
		// Register port writes; privileged ones need system mode
		if (reg_wr_i)
		begin
			case (reg_addr_i)
				mmac_pkg::REG_MODE:
					if (is_sys_w() && !reg_wdata_i[mmac_pkg::MC_PRIV_BIT])
						s_nxt.mode = mmac_pkg::MODE_USER; // [R22]
				mmac_pkg::REG_BOOT_EXIT:
					if (s_r.mode == mmac_pkg::MODE_BOOT)
					begin
						// Later return hands over to system code, never back to boot
						s_nxt.prev = mmac_pkg::MODE_SYS; // [R23]
						s_nxt.mode = (reg_wdata_i[mmac_pkg::BX_TEST_BIT] && s_r.tsync[1])
							? mmac_pkg::MODE_TEST : mmac_pkg::MODE_FW; // [R23]
					end
				mmac_pkg::REG_IRQ_MODE:
					if (is_sys_w() && (reg_wdata_i[2:0] == mmac_pkg::MODE_USER
						|| reg_wdata_i[2:0] == mmac_pkg::MODE_SYS
						|| reg_wdata_i[2:0] == mmac_pkg::MODE_FW))
						s_nxt.irq_mode = mmac_pkg::mmac_mode_e'(reg_wdata_i[2:0]); // [R19]
				mmac_pkg::REG_TBL_BASE:
					if (is_sys_w())
						s_nxt.tbl_base = reg_wdata_i[23:0]; // [R05]
				mmac_pkg::REG_TBL_LOAD:
					if (is_sys_w() && s_r.fst == mmac_pkg::FETCH_IDLE)
					begin
						s_nxt.fst     = mmac_pkg::FETCH_WAIT; // [R05] [R09]
						s_nxt.tbl_ptr = s_r.tbl_base;
						s_nxt.tbl_req = 1'b1;
						s_nxt.fword   = mmac_pkg::FLD_RIGHTS;
						s_nxt.fidx    = '0;
						s_nxt.seg_cnt = '0;
					end
				mmac_pkg::REG_USER_GRP:
					if (is_sys_w())
						s_nxt.user_grp = reg_wdata_i[15:0]; // [R11] [R16]
				mmac_pkg::REG_FW_GRP:
					if (is_sys_w())
						s_nxt.fw_grp = reg_wdata_i[15:0]; // [R11] [R16]
				mmac_pkg::REG_BANKED:
					s_nxt.bank[bank_sel] = reg_wdata_i[15:0]; // [R14]
				default: ;
			endcase
		end
		// Register port reads; unmapped offsets read zero
		if (reg_rd_i)
		begin
			case (reg_addr_i)
				mmac_pkg::REG_MODE:
				begin
					s_nxt.rdata[2:0]                   = s_r.mode;
					s_nxt.rdata[mmac_pkg::MC_EXC_BIT]  = s_r.exc_status;
					s_nxt.rdata[mmac_pkg::MC_IRQ_BIT]  = s_r.irq_active;
					s_nxt.rdata[mmac_pkg::MC_BUSY_BIT] = s_r.fst == mmac_pkg::FETCH_WAIT;
				end
				mmac_pkg::REG_IRQ_MODE:  s_nxt.rdata[2:0] = s_r.irq_mode;
				mmac_pkg::REG_TBL_BASE:  s_nxt.rdata[23:0] = s_r.tbl_base;
				mmac_pkg::REG_USER_GRP:  s_nxt.rdata[15:0] = s_r.user_grp;
				mmac_pkg::REG_FW_GRP:    s_nxt.rdata[15:0] = s_r.fw_grp;
				mmac_pkg::REG_SEG_CNT:   s_nxt.rdata[6:0] = s_r.seg_cnt;
				mmac_pkg::REG_BANKED:    s_nxt.rdata[15:0] = s_r.bank[bank_sel]; // [R14]
				default: ;
			endcase
		end
		// Table fetch: one word per request, entries of five words
		if (s_r.fst == mmac_pkg::FETCH_WAIT && tbl_valid_i)
		begin
			if (s_r.fword == mmac_pkg::FLD_RIGHTS)
			begin
				if (tbl_data_i[2:0] == mmac_pkg::RT_END)
					s_nxt.fst = mmac_pkg::FETCH_IDLE; // [R09]
				else if (tbl_data_i[2:0] == mmac_pkg::RT_LINK)
				begin
					s_nxt.tbl_ptr = tbl_data_i[mmac_pkg::LINK_LSB +: 24]; // [R09]
					s_nxt.tbl_req = 1'b1;
				end
				else
				begin
					seg_we        = 1'b1;
					s_nxt.fword   = mmac_pkg::FLD_START;
					s_nxt.tbl_ptr = s_r.tbl_ptr + mmac_pkg::TBL_STEP;
					s_nxt.tbl_req = 1'b1;
				end
			end
			else
			begin
				seg_we        = 1'b1; // [R06]
				s_nxt.tbl_ptr = s_r.tbl_ptr + mmac_pkg::TBL_STEP;
				if (s_r.fword == mmac_pkg::FLD_SFR)
				begin
					s_nxt.seg_cnt = {1'b0, s_r.fidx} + 7'h01;
					s_nxt.fword   = mmac_pkg::FLD_RIGHTS;
					s_nxt.fidx    = s_r.fidx + 6'h01;
					s_nxt.tbl_req = s_r.fidx != mmac_pkg::SEG_LAST;
					if (s_r.fidx == mmac_pkg::SEG_LAST)
						s_nxt.fst = mmac_pkg::FETCH_IDLE; // [R08]
				end
				else
				begin
					s_nxt.fword   = s_r.fword + 3'h1;
					s_nxt.tbl_req = 1'b1;
				end
			end
		end
	end

	// Privileged register writes are honoured only in system mode
	function automatic logic is_sys_w();
		return s_r.mode == mmac_pkg::MODE_SYS;
	endfunction

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign reg_rdata_o = s_r.rdata;
	assign mem_req_o   = s_r.mem_req;
	assign mem_paddr_o = s_r.mem_paddr;
	assign mem_op_o    = s_r.mem_op;
	assign sfr_grant_o = s_r.sfr_grant;
	assign exc_o       = s_r.exc;
	assign dev_reset_o = s_r.dev_reset;
	assign mode_o      = s_r.mode;
	assign no_push_o   = s_r.no_push;
	assign tbl_req_o   = s_r.tbl_req;
	assign tbl_addr_o  = s_r.tbl_ptr;

	// Checks on mode flow and access decisions
	chk_user_entry_call: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R21]
		cpu_call_i && cpu_vaddr_i == mmac_pkg::USER_ENTRY && s_r.mode == mmac_pkg::MODE_SYS
		&& !cpu_irq_i && !cpu_return_from_interrupt_i && !reg_wr_i |=> mode_o == mmac_pkg::MODE_USER && no_push_o)
		else $error("user entry call did not enter user mode");
	chk_system_call_vector_misuse: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R17]
		cpu_call_i && is_system_call_vector && !is_user |=> exc_o)
		else $error("system vector call outside user mode not trapped");
	chk_double_exc: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R18]
		exc_o ##0 (s_r.exc_status && exc_ev && !cpu_return_from_interrupt_i) |=> dev_reset_o)
		else $error("second exception did not force reset");
	chk_no_boot_back: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R23]
		mode_o != mmac_pkg::MODE_BOOT |=> mode_o != mmac_pkg::MODE_BOOT)
		else $error("boot mode re-entered");
	chk_user_stays_low: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R22]
		is_user && !cpu_call_i && !cpu_irq_i && !cpu_return_from_interrupt_i |=> mode_o != mmac_pkg::MODE_SYS)
		else $error("user mode raised itself to system");
	chk_key_unread: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R12]
		cpu_sfr_req_i && !cpu_sfr_wr_i && cpu_sfr_addr_i >= mmac_pkg::SFR_PERIPH_BASE
		&& cpu_sfr_addr_i[mmac_pkg::SFR_GRP_LSB +: 4] == mmac_pkg::SFR_KEY_GRP
		|=> !sfr_grant_o && exc_o)
		else $error("key register read was granted");
	chk_unimpl_trap: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R10]
		cpu_req_i && !acc_impl && s_r.mode != mmac_pkg::MODE_TEST |=> exc_o && !mem_req_o)
		else $error("unimplemented memory access not trapped");
	chk_irq_target: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R19]
		cpu_irq_i && !cpu_return_from_interrupt_i && !reg_wr_i |=> mode_o == ($past(s_r.irq_mode)
		== mmac_pkg::MODE_BOOT ? mmac_pkg::MODE_SYS : $past(s_r.irq_mode)))
		else $error("interrupt entered the wrong mode");
	chk_fw_block: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R16]
		cpu_sfr_req_i && s_r.mode == mmac_pkg::MODE_FW
		&& cpu_sfr_addr_i >= mmac_pkg::SFR_PERIPH_BASE
		&& !s_r.fw_grp[cpu_sfr_addr_i[mmac_pkg::SFR_GRP_LSB +: 4]] |=> !sfr_grant_o && exc_o)
		else $error("ungranted group reached in firmware mode");
endmodule

// ==== mmac_tbl_mem.sv ====
// Table memory model answering segment table word fetches
`timescale 1ns/100ps
module mmac_tbl_mem
#(
	parameter int LAT = 2
)
(
	input  wire logic        core_clk_i,
	input  wire logic        tbl_req_i,
	input  wire logic [23:0] tbl_addr_i,
	output logic [31:0]      tbl_data_o,
	output logic             tbl_valid_o
);
	logic [31:0] mem [0:255];
	logic [23:0] addr_r;
	int          wait_r = 0;
	initial tbl_valid_o = 1'h0;
	initial tbl_data_o = 32'h0;
	// Word after LAT cycles; idle data flips so a stale word never reads as valid
	always @(posedge core_clk_i)
	begin
		tbl_valid_o <= (wait_r == 1);
		tbl_data_o <= (wait_r == 1) ? mem[addr_r[9:2]] : ~tbl_data_o;
		wait_r <= tbl_req_i ? LAT : (wait_r > 0 ? wait_r - 1 : 0);
		if (tbl_req_i)
			addr_r <= tbl_addr_i;
	end
endmodule

// ==== tb.sv ====
// Self-checking bench for the address translation and mode control block
`timescale 1ns/100ps
module tb;
	logic        core_clk_i, rst_i, reg_wr_i, reg_rd_i, test_allow_i, cpu_req_i, cpu_sfr_req_i;
	logic        cpu_sfr_wr_i, cpu_call_i, cpu_return_from_interrupt_i, cpu_irq_i, tbl_valid_i;
	logic        mem_req_o, sfr_grant_o, exc_o, dev_reset_o, no_push_o, tbl_req_o;
	logic [1:0]  cpu_op_i, mem_op_o;
	logic [2:0]  mode_o;
	logic [7:0]  reg_addr_i, cpu_sfr_addr_i;
	logic [23:0] cpu_vaddr_i, mem_paddr_o, tbl_addr_o;
	logic [31:0] reg_wdata_i, reg_rdata_o, tbl_data_i, d;
	int          fails = 0;
	int          samples_checked = 0;
	mmac_core u_mmac_core (.*);
	// Slow table memory so the fetch sequencer has to wait
	mmac_tbl_mem #(.LAT(3)) u_mmac_tbl_mem (.core_clk_i, .tbl_req_i(tbl_req_o),
		.tbl_addr_i(tbl_addr_o), .tbl_data_o(tbl_data_i), .tbl_valid_o(tbl_valid_i));
	// 20 MHz core clock
	always #25 core_clk_i = ~core_clk_i;
	// Compare and count
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Verdict and end of run
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// One register port cycle; read data lands in d the cycle after the strobe
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge core_clk_i);
		reg_wr_i <= w;
		reg_rd_i <= !w;
		reg_addr_i <= a;
		reg_wdata_i <= wd;
		@(posedge core_clk_i);
		{reg_wr_i, reg_rd_i} <= 2'h0;
		#1 d = reg_rdata_o;
	endtask
	// CPU event k: 0 access, 1 register, 2 call, 3 return, 4 interrupt; exp 1 judges reset only
	task automatic cpu(input logic [2:0] k, input logic [23:0] a, input logic [1:0] op,
		input logic [3:0] exp, input string what);
		logic [3:0] seen;
		@(posedge core_clk_i);
		{cpu_req_i, cpu_sfr_req_i, cpu_call_i, cpu_return_from_interrupt_i, cpu_irq_i} <= 5'h10 >> k;
		cpu_vaddr_i <= a;
		cpu_sfr_addr_i <= a[7:0];
		cpu_op_i <= op;
		cpu_sfr_wr_i <= op[0];
		@(posedge core_clk_i);
		{cpu_req_i, cpu_sfr_req_i, cpu_call_i, cpu_return_from_interrupt_i, cpu_irq_i} <= 5'h0;
		#1 seen = {mem_req_o, sfr_grant_o, exc_o, dev_reset_o};
		check(what, exp == 4'h1 ? {3'h0, dev_reset_o} : seen, exp);
	endtask
	// Fresh reset, leave boot, and return into system mode when asked
	task automatic boot_to(input logic [2:0] tgt);
		@(posedge core_clk_i);
		rst_i <= 1'h1;
		test_allow_i <= (tgt == 3'h1);
		repeat (16) @(posedge core_clk_i);
		rst_i <= 1'h0;
		repeat (2) @(posedge core_clk_i);
		#1 check("boot", mode_o, mmac_pkg::MODE_BOOT);
		bus(1'h1, 8'h04, 32'h1);
		bus(1'h1, 8'h04, 32'h1);
		check("exit", mode_o, tgt == 3'h1 ? 3'h1 : 3'h2);
		if (tgt == 3'h3)
			cpu(2'h3, 24'h0, 2'h0, 4'h0, "return_from_interrupt");
		check("mode", mode_o, tgt);
	endtask
	// Firmware sees only its partition; ungranted group and a second trap
	task automatic s_fw();
		boot_to(3'h2);
		cpu(2'h0, 24'h302010, 2'h0, 4'h8, "fw ram");
		check("paddr", mem_paddr_o, 24'h302010);
		cpu(2'h1, 24'hC4, 2'h0, 4'h2, "fw grp");
		cpu(2'h0, 24'h300010, 2'h0, 4'h1, "app ram");
	endtask
	// Test mode reaches both partitions
	task automatic s_test();
		boot_to(3'h1);
		cpu(2'h0, 24'h302010, 2'h0, 4'h8, "t fw");
		cpu(2'h0, 24'h300010, 2'h1, 4'h8, "t app");
		cpu(2'h1, 24'h80, 2'h0, 4'h2, "unimpl");
		bus(1'h1, 8'h20, 32'hA5);
		bus(1'h0, 8'h20, 32'h0);
		check("bank", d, 32'hA5);
	endtask
	// System mode registers, unreadable key, vector misuse
	task automatic s_sys();
		boot_to(3'h3);
		cpu(2'h0, 24'h300010, 2'h1, 4'h8, "s ram");
		check("op", mem_op_o, 2'h1);
		cpu(2'h1, 24'hC8, 2'h1, 4'h4, "key wr");
		cpu(2'h1, 24'h10, 2'h0, 4'h4, "core rd");
		cpu(2'h1, 24'hC8, 2'h0, 4'h2, "key rd");
		cpu(2'h2, 24'hFF0000, 2'h0, 4'h1, "system_call_vector");
	endtask
	// Linked table of three segments, then user mode checks
	task automatic s_user();
		logic [31:0] w [0:16] = '{32'h2, 32'h1000, 32'h1FFF, 32'h2FF000, 32'h0, 32'h20006,
			32'h1, 32'h2000, 32'h2FFF, 32'hFE000, 32'h2, 32'h2, 32'h3000, 32'h3FFF,
			32'h2FF000, 32'h0, 32'h7};
		boot_to(3'h3);
		foreach (w[i])
			u_mmac_tbl_mem.mem[i < 6 ? 8'h40 + i : 8'h7A + i] = w[i];
		bus(1'h1, 8'h0C, 32'h100);
		bus(1'h1, 8'h10, 32'h1);
		d = 32'h20;
		for (int n = 0; n < 60 && d[5] !== 1'h0; n++)
			bus(1'h0, 8'h00, 32'h0);
		if (d[5] !== 1'h0)
		begin
			fails++;
			summarize();
		end
		bus(1'h0, 8'h1C, 32'h0);
		check("segs", d, 32'h3);
		bus(1'h1, 8'h14, 32'h2);
		bus(1'h1, 8'h08, 32'h3);
		bus(1'h1, 8'h20, 32'h5A);
		cpu(2'h2, 24'h800000, 2'h0, 4'h0, "entry");
		check("push", no_push_o, 1'h1);
		bus(1'h1, 8'h00, 32'h1);
		check("user", mode_o, mmac_pkg::MODE_USER);
		bus(1'h0, 8'h20, 32'h0);
		check("bank", d, 32'h0);
		cpu(2'h0, 24'h1000, 2'h0, 4'h8, "lo");
		check("reloc", mem_paddr_o, 24'h300000);
		cpu(2'h0, 24'h1FFF, 2'h1, 4'h8, "hi");
		check("reloc", mem_paddr_o, 24'h300FFF);
		cpu(2'h0, 24'h2000, 2'h2, 4'h8, "exec");
		cpu(2'h1, 24'hC4, 2'h0, 4'h4, "grp");
		cpu(3'h4, 24'h0, 2'h0, 4'h0, "irq");
		check("irq mode", mode_o, mmac_pkg::MODE_SYS);
		cpu(2'h3, 24'h0, 2'h0, 4'h0, "return_from_interrupt");
		check("back", mode_o, mmac_pkg::MODE_USER);
		cpu(2'h0, 24'h3000, 2'h0, 4'h2, "part");
		cpu(2'h0, 24'h1010, 2'h2, 4'h1, "rw fetch");
	endtask
	// Main sequence
	initial
	begin
		core_clk_i = 1'h0;
		rst_i = 1'h1;
		{reg_wr_i, reg_rd_i, test_allow_i, cpu_req_i, cpu_sfr_req_i, cpu_sfr_wr_i} = '0;
		{cpu_call_i, cpu_return_from_interrupt_i, cpu_irq_i, cpu_op_i, reg_addr_i, cpu_sfr_addr_i} = '0;
		{cpu_vaddr_i, reg_wdata_i} = '0;
		s_fw();
		s_test();
		s_sys();
		s_user();
		summarize();
	end
endmodule
